/* verilog/fir_cfg_pkg.sv */
// Shared constants and types for the equaliser configuration and gain trim block
package fir_cfg_pkg;

   // -----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam int           IDX_W                = 12;
   localparam logic [11:0]  IDX_GAIN_A0_DUAL     = 12'h350;
   localparam logic [11:0]  IDX_GAIN_A1_DUAL     = 12'h351;
   localparam logic [11:0]  IDX_GAIN_B0_DUAL     = 12'h352;
   localparam logic [11:0]  IDX_GAIN_B1_DUAL     = 12'h353;
   localparam logic [11:0]  IDX_GAIN_A0_SINGLE   = 12'h354;
   localparam logic [11:0]  IDX_GAIN_A1_SINGLE   = 12'h355;
   localparam logic [11:0]  IDX_GAIN_B0_SINGLE   = 12'h356;
   localparam logic [11:0]  IDX_GAIN_B1_SINGLE   = 12'h357;
   localparam logic [11:0]  IDX_FILTER_CFG       = 12'h400;
   localparam logic [11:0]  IDX_COEFF_A_FIRST    = 12'h418;
   localparam logic [11:0]  IDX_COEFF_B_FIRST    = 12'h480;
   localparam logic [11:0]  IDX_STATUS           = 12'h4F0;

   // -----------------------------------------------------------------
   // Field layouts and reset values
   // -----------------------------------------------------------------
   localparam int           TRIM_W               = 5;
   localparam int           TRIM_COUNT           = 8;
   localparam logic [4:0]   TRIM_RESET           = 5'h00;
   localparam int           CFG_SHARE_BIT        = 6;
   localparam int           CFG_MERGE_BIT        = 5;
   localparam int           CFG_SCW_LSB          = 2;
   localparam int           CFG_SCW_MSB          = 4;
   localparam int           CFG_MODE_LSB         = 0;
   localparam int           CFG_MODE_MSB         = 1;
   localparam logic [7:0]   CFG_RESET            = 8'h00;
   localparam logic [6:0]   CFG_WRITE_MASK       = 7'h7F;
   localparam logic [1:0]   MODE_OFF             = 2'h0;
   localparam logic [1:0]   MODE_ON              = 2'h2;
   localparam logic [4:0]   SCW_BASE             = 5'h10;
   localparam int           COEFF_W              = 12;
   localparam logic [11:0]  COEFF_RESET          = 12'h000;
   localparam int           STAT_LINK_BIT        = 0;
   localparam int           STAT_ACTIVE_BIT      = 1;
   localparam int           STAT_WR_LINKED_BIT   = 2;
   localparam int           STAT_FUSE_DONE_BIT   = 3;
   localparam logic [1:0]   FUSE_SETTLE          = 2'h2;

   typedef enum logic [2:0] {
      LOAD_SYNC = 3'b001,
      LOAD_TAKE = 3'b010,
      LOAD_DONE = 3'b100
   } fuse_state_t;

endpackage

/* verilog/trim_if.sv */
// Carrier between the register logic and the gain trim storage
`timescale 1ns/1ps
interface trim_if;
   import fir_cfg_pkg::*;
   logic                                 wr_stb;
   logic [2:0]                           wr_idx;
   logic [TRIM_W-1:0]                    wr_data;
   logic                                 load_stb;
   logic [TRIM_COUNT-1:0][TRIM_W-1:0]    fuse_word;
   logic [TRIM_COUNT-1:0][TRIM_W-1:0]    trim;

   modport ctrl (output wr_stb, output wr_idx, output wr_data, output load_stb, output fuse_word, input trim);
   modport bank (input wr_stb, input wr_idx, input wr_data, input load_stb, input fuse_word, output trim);
endinterface

/* verilog/gain_trim_bank.sv */
// Eight fine gain trim values: dual set in entries 0..3, single set in 4..7
`timescale 1ns/1ps
module gain_trim_bank
   import fir_cfg_pkg::*;
(
   input  wire logic  mclk,
   input  wire logic  rstn,
   trim_if.bank       tb
);

   genvar i;
   generate
      for (i = 0; i < TRIM_COUNT; i++) begin : g_trim
         logic [TRIM_W-1:0] trim_ff;
         // Fuse load happens once after reset, before software may write
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               trim_ff <= TRIM_RESET;
            end else if (tb.load_stb) begin
               trim_ff <= tb.fuse_word[i];
            end else if (tb.wr_stb && (tb.wr_idx == 3'(i))) begin
               trim_ff <= tb.wr_data;
            end
         end
         assign tb.trim[i] = trim_ff;
      end
   endgenerate

endmodule

/* verilog/equaliser_stage.sv */
// One channel of the equaliser: unity centre tap plus one weighted side tap
`timescale 1ns/1ps
module equaliser_stage
   import fir_cfg_pkg::*;
#(
   parameter int DATA_W = 12
)(
   input  wire logic                        mclk,
   input  wire logic                        rstn,
   input  wire logic signed [DATA_W-1:0]    sample_cur,
   input  wire logic signed [DATA_W-1:0]    sample_prev,
   input  wire logic signed [COEFF_W-1:0]   coeff,
   input  wire logic [2:0]                  scw,
   input  wire logic                        enable,
   output logic signed [DATA_W+1:0]         sample_out
);

   localparam int PROD_W = DATA_W + COEFF_W;
   localparam int OUT_W  = DATA_W + 2;

   logic signed [PROD_W-1:0] product;
   logic signed [PROD_W-1:0] scaled;
   logic [4:0]               shift_amt;
   logic signed [OUT_W-1:0]  cur_ext;
   logic signed [OUT_W-1:0]  filtered;
   logic signed [OUT_W-1:0]  sample_out_ff;

   // Side tap LSB weight is 2^(scw-16); codes above 6 are not legal
   assign product   = sample_prev * coeff;
   assign shift_amt = SCW_BASE - {2'b00, scw};
   assign scaled    = product >>> shift_amt;
   assign cur_ext   = OUT_W'(sample_cur);
   // Two guard bits keep the sum from wrapping for every legal weight
   assign filtered  = cur_ext + OUT_W'(scaled);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sample_out_ff <= '0;
      end else begin
         sample_out_ff <= enable ? filtered : cur_ext;
      end
   end

   assign sample_out = sample_out_ff;

endmodule

/* verilog/fir_config_and_gain_trim.sv */
// Equaliser configuration, coefficient and fine gain trim registers behind APB
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module fir_config_and_gain_trim
   import fir_cfg_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 12
)(
   input  wire logic                               mclk,
   input  wire logic                               rstn,
   input  wire logic                               psel,
   input  wire logic                               penable,
   input  wire logic                               pwrite,
   input  wire logic [ADDR_W-1:0]                  paddr,
   input  wire logic [31:0]                        pwdata,
   input  wire logic [3:0]                         pstrb,
   output logic [31:0]                             prdata,
   output logic                                    pready,
   output logic                                    pslverr,
   input  wire logic [TRIM_COUNT*TRIM_W-1:0]       fuse_trim,
   input  wire logic                               serial_link_enable,
   input  wire logic signed [DATA_W-1:0]           sample_a_in,
   input  wire logic signed [DATA_W-1:0]           sample_b_in,
   output logic signed [DATA_W+1:0]                sample_a_out,
   output logic signed [DATA_W+1:0]                sample_b_out,
   output logic [TRIM_COUNT*TRIM_W-1:0]            gain_trim,
   output logic                                    filter_active
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   trim_if tb ();

   logic                                 link_meta_ff;
   logic                                 link_sync_ff;
   logic [TRIM_COUNT*TRIM_W-1:0]         fuse_meta_ff;
   logic [TRIM_COUNT*TRIM_W-1:0]         fuse_sync_ff;
   fuse_state_t                          fuse_state_ff;
   fuse_state_t                          nxt_fuse_state;
   logic [1:0]                           settle_cnt_ff;

   logic [7:0]                           cfg_ff;
   logic [COEFF_W-1:0]                   coeff_a_ff;
   logic [COEFF_W-1:0]                   coeff_b_ff;
   logic                                 wr_linked_ff;
   logic                                 filter_active_ff;
   logic signed [DATA_W-1:0]             a_prev_ff;
   logic signed [DATA_W-1:0]             b_prev_ff;

   logic                                 pready_ff;
   logic                                 pslverr_ff;
   logic [31:0]                          prdata_ff;

   logic [IDX_W-1:0]                     idx;
   logic                                 aligned;
   logic                                 is_trim;
   logic                                 is_cfg;
   logic                                 is_coeff_a;
   logic                                 is_coeff_b;
   logic                                 is_status;
   logic                                 mapped;
   logic                                 access;
   logic                                 commit_wr;
   logic                                 lane0;
   logic                                 lane1;
   logic [31:0]                          rd_value;
   logic [1:0]                           mode;
   logic [2:0]                           scw;
   logic                                 share;
   logic                                 merge;
   logic signed [DATA_W-1:0]             prev_for_a;
   logic signed [DATA_W-1:0]             prev_for_b;
   logic signed [COEFF_W-1:0]            coeff_for_b;

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         link_meta_ff <= 1'b0;
         link_sync_ff <= 1'b0;
      end else begin
         link_meta_ff <= serial_link_enable;
         link_sync_ff <= link_meta_ff;
      end
   end

   // Fuse outputs are static, but they still cross in from outside
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         fuse_meta_ff <= '0;
         fuse_sync_ff <= '0;
      end else begin
         fuse_meta_ff <= fuse_trim;
         fuse_sync_ff <= fuse_meta_ff;
      end
   end

   // -----------------------------------------------------------------
   // Fuse default load after reset release
   // -----------------------------------------------------------------
   always_comb begin
      nxt_fuse_state = fuse_state_ff;
      case (fuse_state_ff)
         LOAD_SYNC: begin
            if (settle_cnt_ff == FUSE_SETTLE) begin
               nxt_fuse_state = LOAD_TAKE;
            end
         end
         LOAD_TAKE: nxt_fuse_state = LOAD_DONE;
         LOAD_DONE: nxt_fuse_state = LOAD_DONE;
         default:   nxt_fuse_state = LOAD_SYNC;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         fuse_state_ff <= LOAD_SYNC;
      end else begin
         fuse_state_ff <= nxt_fuse_state;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         settle_cnt_ff <= '0;
      end else if (fuse_state_ff == LOAD_SYNC) begin
         settle_cnt_ff <= settle_cnt_ff + 2'h1;
      end
   end

   assign tb.load_stb  = (fuse_state_ff == LOAD_TAKE);
   assign tb.fuse_word = fuse_sync_ff;

   // -----------------------------------------------------------------
   // APB decode
   // -----------------------------------------------------------------
   assign idx        = paddr[IDX_W+1:2];
   assign aligned    = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:IDX_W+2] == '0);
   assign is_trim    = aligned && (idx >= IDX_GAIN_A0_DUAL) && (idx <= IDX_GAIN_B1_SINGLE);
   assign is_cfg     = aligned && (idx == IDX_FILTER_CFG);
   assign is_coeff_a = aligned && (idx == IDX_COEFF_A_FIRST);
   assign is_coeff_b = aligned && (idx == IDX_COEFF_B_FIRST);
   assign is_status  = aligned && (idx == IDX_STATUS);
   assign mapped     = is_trim || is_cfg || is_coeff_a || is_coeff_b || is_status;

   // One wait state: pready rises on the second access cycle
   assign access    = psel && penable && !pready_ff;
   assign commit_wr = psel && penable && pready_ff && pwrite && !pslverr_ff;
   assign lane0     = pstrb[0];
   assign lane1     = pstrb[1];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= access;
         pslverr_ff <= access && !mapped;
      end
   end

   // -----------------------------------------------------------------
   // Register writes
   // -----------------------------------------------------------------
   // Trim writes during the fuse load are dropped so the defaults are not torn
   assign tb.wr_stb  = commit_wr && is_trim && lane0 && (fuse_state_ff == LOAD_DONE);
   assign tb.wr_idx  = idx[2:0];
   assign tb.wr_data = pwdata[TRIM_W-1:0];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cfg_ff <= CFG_RESET;
      end else if (commit_wr && is_cfg && lane0) begin
         cfg_ff <= {1'b0, pwdata[6:0] & CFG_WRITE_MASK};
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         coeff_a_ff <= COEFF_RESET;
      end else if (commit_wr && is_coeff_a) begin
         if (lane0) begin
            coeff_a_ff[7:0] <= pwdata[7:0];
         end
         if (lane1) begin
            coeff_a_ff[COEFF_W-1:8] <= pwdata[COEFF_W-1:8];
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         coeff_b_ff <= COEFF_RESET;
      end else if (commit_wr && is_coeff_b) begin
         if (lane0) begin
            coeff_b_ff[7:0] <= pwdata[7:0];
         end
         if (lane1) begin
            coeff_b_ff[COEFF_W-1:8] <= pwdata[COEFF_W-1:8];
         end
      end
   end

   // Sticky flag: a filter setting changed while the link ran; set beats clear
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wr_linked_ff <= 1'b0;
      end else if (commit_wr && link_sync_ff && (is_trim || is_cfg || is_coeff_a || is_coeff_b)) begin
         wr_linked_ff <= 1'b1;
      end else if (commit_wr && is_status && lane0 && pwdata[STAT_WR_LINKED_BIT]) begin
         wr_linked_ff <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Register reads
   // -----------------------------------------------------------------
   always_comb begin
      rd_value = 32'h0000_0000;
      if (is_trim) begin
         rd_value[TRIM_W-1:0] = tb.trim[idx[2:0]];
      end else if (is_cfg) begin
         rd_value[7:0] = cfg_ff;
      end else if (is_coeff_a) begin
         rd_value[COEFF_W-2:0] = coeff_a_ff[COEFF_W-2:0];
      end else if (is_coeff_b) begin
         rd_value[COEFF_W-2:0] = coeff_b_ff[COEFF_W-2:0];
      end else if (is_status) begin
         rd_value[STAT_LINK_BIT]      = link_sync_ff;
         rd_value[STAT_ACTIVE_BIT]    = filter_active_ff;
         rd_value[STAT_WR_LINKED_BIT] = wr_linked_ff;
         rd_value[STAT_FUSE_DONE_BIT] = (fuse_state_ff == LOAD_DONE);
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (access) begin
         prdata_ff <= pwrite ? 32'h0000_0000 : rd_value;
      end
   end

   // -----------------------------------------------------------------
   // Filter steering
   // -----------------------------------------------------------------
   assign mode  = cfg_ff[CFG_MODE_MSB:CFG_MODE_LSB];
   assign scw   = cfg_ff[CFG_SCW_MSB:CFG_SCW_LSB];
   assign share = cfg_ff[CFG_SHARE_BIT];
   assign merge = cfg_ff[CFG_MERGE_BIT];

   // Reserved mode codes fall back to bypass
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         filter_active_ff <= 1'b0;
      end else begin
         filter_active_ff <= (mode == MODE_ON);
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         a_prev_ff <= '0;
         b_prev_ff <= '0;
      end else begin
         a_prev_ff <= sample_a_in;
         b_prev_ff <= sample_b_in;
      end
   end

   // Merged stream order per cycle is A then B, so each sees the other as its predecessor
   assign prev_for_a  = merge ? b_prev_ff : a_prev_ff;
   assign prev_for_b  = merge ? sample_a_in : b_prev_ff;
   assign coeff_for_b = share ? coeff_a_ff : coeff_b_ff;

   // -----------------------------------------------------------------
   // Instances
   // -----------------------------------------------------------------
   gain_trim_bank u_trim (
      .mclk (mclk),
      .rstn (rstn),
      .tb   (tb.bank)
   );

   equaliser_stage #(.DATA_W(DATA_W)) u_stage_a (
      .mclk        (mclk),
      .rstn        (rstn),
      .sample_cur  (sample_a_in),
      .sample_prev (prev_for_a),
      .coeff       (coeff_a_ff),
      .scw         (scw),
      .enable      (filter_active_ff),
      .sample_out  (sample_a_out)
   );

   equaliser_stage #(.DATA_W(DATA_W)) u_stage_b (
      .mclk        (mclk),
      .rstn        (rstn),
      .sample_cur  (sample_b_in),
      .sample_prev (prev_for_b),
      .coeff       (coeff_for_b),
      .scw         (scw),
      .enable      (filter_active_ff),
      .sample_out  (sample_b_out)
   );

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign prdata        = prdata_ff;
   assign pready        = pready_ff;
   assign pslverr       = pslverr_ff;
   assign gain_trim     = tb.trim;
   assign filter_active = filter_active_ff;

endmodule

/* test/fir_cfg_sva.sv */
// Port-level checks for the equaliser configuration and gain trim block
`timescale 1ns/1ps
module fir_cfg_sva
   import fir_cfg_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 12
)(
   input wire logic                           mclk,
   input wire logic                           rstn,
   input wire logic                           psel,
   input wire logic                           penable,
   input wire logic                           pwrite,
   input wire logic [ADDR_W-1:0]              paddr,
   input wire logic [31:0]                    pwdata,
   input wire logic [3:0]                     pstrb,
   input wire logic [31:0]                    prdata,
   input wire logic                           pready,
   input wire logic                           pslverr,
   input wire logic [TRIM_COUNT*TRIM_W-1:0]   fuse_trim,
   input wire logic                           serial_link_enable,
   input wire logic signed [DATA_W-1:0]       sample_a_in,
   input wire logic signed [DATA_W-1:0]       sample_b_in,
   input wire logic signed [DATA_W+1:0]       sample_a_out,
   input wire logic signed [DATA_W+1:0]       sample_b_out,
   input wire logic [TRIM_COUNT*TRIM_W-1:0]   gain_trim,
   input wire logic                           filter_active
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   logic rd_done;
   assign rd_done = psel && penable && pready && !pwrite;
   // ----------------------------------------
   // Bus timing
   // ----------------------------------------
   property p_ready_next; psel && penable && !pready |=> pready; endproperty
   a_ready_next: assert property (p_ready_next) else $error("pready missing after access");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   property p_ready_idle; !(psel && penable) |=> !pready; endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("pready without access");
   property p_err_unaligned; psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
   a_err_unaligned: assert property (p_err_unaligned) else $error("unaligned access not refused");
   // ----------------------------------------
   // Register contents
   // ----------------------------------------
   property p_trim_rd; rd_done && paddr[15:5] == 11'h06A |-> prdata[31:5] == 27'h0; endproperty
   a_trim_rd: assert property (p_trim_rd) else $error("trim reserved bits read nonzero");
   property p_cfg_rd; rd_done && paddr == {2'b00, IDX_FILTER_CFG, 2'b00} |-> prdata[31:7] == 25'h0; endproperty
   a_cfg_rd: assert property (p_cfg_rd) else $error("config reserved bit read nonzero");
   property p_coeff_rd; rd_done && paddr == {2'b00, IDX_COEFF_A_FIRST, 2'b00} |-> prdata[31:11] == 21'h0; endproperty
   a_coeff_rd: assert property (p_coeff_rd) else $error("coefficient top bits read nonzero");
   property p_fuse; $rose(rstn) |-> ##[1:6] gain_trim == fuse_trim; endproperty
   a_fuse: assert property (p_fuse) else $error("trims not loaded from fuses");
   property p_active;
      logic on;
      (psel && penable && pready && pwrite && pstrb[0] && paddr == {2'b00, IDX_FILTER_CFG, 2'b00},
       on = (pwdata[1:0] == MODE_ON)) |-> ##2 filter_active == on;
   endproperty
   a_active: assert property (p_active) else $error("filter_active does not follow mode");
   // The stage register still takes its reset branch at the release edge
   property p_bypass; rstn && !filter_active ##1 !filter_active
      |-> sample_a_out == {{2{$past(sample_a_in[11])}}, $past(sample_a_in)};
   endproperty
   a_bypass: assert property (p_bypass) else $error("disabled filter altered samples");
   c_err: cover property (pready && pslverr);
   c_active: cover property ($rose(filter_active));
   c_fuse: cover property ($rose(rstn) ##6 gain_trim == fuse_trim);
endmodule

bind fir_config_and_gain_trim fir_cfg_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) fir_cfg_sva_inst (
   .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .fuse_trim(fuse_trim), .serial_link_enable(serial_link_enable), .sample_a_in(sample_a_in),
   .sample_b_in(sample_b_in), .sample_a_out(sample_a_out), .sample_b_out(sample_b_out),
   .gain_trim(gain_trim), .filter_active(filter_active));

/* test/fir_config_and_gain_trim_tb_top.sv */
// Self-checking bench for the equaliser configuration and gain trim block
`timescale 1ns/1ps
module fir_config_and_gain_trim_tb_top;
   import fir_cfg_pkg::*;
   typedef struct {logic [11:0] idx; logic [31:0] wd; logic [3:0] st; logic [31:0] rd; logic err;} row_t;
   logic               mclk = 1'b0;
   logic               rstn = 1'b0;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [15:0]        paddr = 16'h0000;
   logic [31:0]        pwdata = 32'h0000_0000;
   logic [3:0]         pstrb = 4'h0;
   logic [39:0]        fuse_trim = 40'h00_0000_0000;
   logic               link_en = 1'b0;
   logic signed [11:0] a_in = 12'sh000;
   logic signed [11:0] b_in = 12'sh000;
   logic [31:0]        prdata, rd;
   logic               pready, pslverr, filter_active, err;
   logic signed [13:0] a_out, b_out;
   logic [39:0]        gain_trim;
   int                 errors = 0;
   int                 n_compared = 0;
   // Write then read back; lane and reserved-bit cases ride along
   row_t rows [0:8] = '{
      '{IDX_GAIN_A0_DUAL,   32'hFFFF_FFFF, 4'hF, 32'h0000_001F, 1'b0},
      '{IDX_GAIN_B1_SINGLE, 32'h0000_000A, 4'hF, 32'h0000_000A, 1'b0},
      '{IDX_FILTER_CFG,     32'h0000_00FF, 4'hF, 32'h0000_007F, 1'b0},
      '{IDX_FILTER_CFG,     32'h0000_0000, 4'h0, 32'h0000_007F, 1'b0},
      '{IDX_FILTER_CFG,     32'h0000_0000, 4'h1, 32'h0000_0000, 1'b0},
      '{IDX_COEFF_A_FIRST,  32'h0000_FFFF, 4'hF, 32'h0000_07FF, 1'b0},
      '{IDX_COEFF_A_FIRST,  32'h0000_0ABC, 4'h2, 32'h0000_02FF, 1'b0},
      '{IDX_COEFF_B_FIRST,  32'h0000_0123, 4'h3, 32'h0000_0123, 1'b0},
      '{12'h3FF,            32'h0000_0055, 4'hF, 32'h0000_0000, 1'b1}};
   always #4 mclk = ~mclk;
   fir_config_and_gain_trim fir_config_and_gain_trim_inst (
      .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fuse_trim(fuse_trim), .serial_link_enable(link_en), .sample_a_in(a_in), .sample_b_in(b_in),
      .sample_a_out(a_out), .sample_b_out(b_out), .gain_trim(gain_trim), .filter_active(filter_active));
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [15:0] ba(input logic [11:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   // Request held until pready is sampled high; no fixed latency assumed
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd, input logic [3:0] st);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      pstrb <= st;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         tally_and_finish();
      end
   endtask
   task automatic wr_reg(input logic [11:0] i, input logic [31:0] v);
      apb(1'b1, ba(i), v, 4'hF);
   endtask
   task automatic rd_chk(input string what, input logic [11:0] i, input logic [31:0] exp);
      apb(1'b0, ba(i), 32'h0000_0000, 4'h0);
      chk(what, {8'h00, exp}, {8'h00, rd});
   endtask
   task automatic reset_and_load(input logic [39:0] f);
      int n;
      n = 0;
      fuse_trim <= f;
      rstn <= 1'b0;
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      do begin
         apb(1'b0, ba(IDX_STATUS), 32'h0000_0000, 4'h0);
         n++;
      end while (rd[STAT_FUSE_DONE_BIT] !== 1'b1 && n < 10);
      if (rd[STAT_FUSE_DONE_BIT] !== 1'b1) begin
         errors++;
         tally_and_finish();
      end
      chk("gain_trim", f, gain_trim);
      rd_chk("cfg_reset", IDX_FILTER_CFG, 32'h0000_0000);
   endtask
   // Program config, hold samples steady, compare both channel outputs
   task automatic dp(input logic [7:0] cfg, input logic signed [11:0] a, input logic signed [11:0] b,
                     input logic signed [13:0] ea, input logic signed [13:0] eb);
      wr_reg(IDX_FILTER_CFG, {24'h00_0000, cfg});
      a_in <= a;
      b_in <= b;
      repeat (4) @(posedge mclk);
      chk("filter_active", {39'h0, cfg[1:0] == MODE_ON}, {39'h0, filter_active});
      chk("sample_a_out", {26'h0, ea}, {26'h0, a_out});
      chk("sample_b_out", {26'h0, eb}, {26'h0, b_out});
   endtask
   initial begin
      reset_and_load(40'h01_2345_6789);
      rd_chk("coeff_reset", IDX_COEFF_A_FIRST, 32'h0000_0000);
      foreach (rows[i]) begin
         apb(1'b1, ba(rows[i].idx), rows[i].wd, rows[i].st);
         chk("write_err", {39'h0, rows[i].err}, {39'h0, err});
         apb(1'b0, ba(rows[i].idx), 32'h0000_0000, 4'h0);
         chk("read_data", {8'h00, rows[i].rd}, {8'h00, rd});
      end
      wr_reg(IDX_GAIN_A0_DUAL, 32'h0000_0003);
      wr_reg(IDX_GAIN_A0_SINGLE, 32'h0000_001C);
      @(posedge mclk);
      chk("trim_dual_a0", 40'h00_0000_0003, {35'h0, gain_trim[4:0]});
      chk("trim_single_a0", 40'h00_0000_001C, {35'h0, gain_trim[24:20]});
      apb(1'b1, 16'h1001, 32'h0000_0002, 4'hF);
      chk("unaligned_err", 40'h00_0000_0001, {39'h0, err});
      rd_chk("cfg_kept", IDX_FILTER_CFG, 32'h0000_0000);
      wr_reg(IDX_COEFF_A_FIRST, 32'h0000_0400);
      wr_reg(IDX_COEFF_B_FIRST, 32'h0000_0000);
      for (int s = 0; s < 7; s++) begin
         dp({3'b000, s[2:0], MODE_ON}, 12'sh400, 12'sh400, 14'sd1024 + (14'sd1 <<< (4 + s)), 14'sd1024);
      end
      for (int m = 0; m < 4; m++) begin
         dp({3'b000, 3'h6, m[1:0]}, -12'sd1024, 12'sh400, (m == 2) ? -14'sd2048 : -14'sd1024, 14'sd1024);
      end
      dp(8'h5A, 12'sh400, 12'sh400, 14'sd2048, 14'sd2048);
      dp(8'h7A, 12'sh400, 12'sh000, 14'sd1024, 14'sd1024);
      link_en <= 1'b1;
      rd_chk("status", IDX_STATUS, 32'h0000_000B);
      link_en <= 1'b0;
      reset_and_load(40'hFE_DCBA_9876);
      tally_and_finish();
   end
endmodule
